/* amc_mem_model.sv */
module amc_mem_model (
  input wire logic clk_i,
  input wire logic [1:0] chip_select_n_i,
  input wire logic output_enable_n_i,
  input wire logic write_enable_n_i,
  input wire logic [15:0] bus_i,
  input wire logic [7:0] wait_len_i,
  output logic [15:0] data_o,
  output logic ext_wait_in_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] store [2];
  logic [15:0] flip = 16'h0000;
  logic [7:0] hold_cnt = 8'h00;
  logic stb_d = 1'b1;
  logic sel;
  logic stb;
  assign sel = ~chip_select_n_i[1];
  assign stb = output_enable_n_i & write_enable_n_i;
  // released bus shows a pattern that changes every cycle
  assign data_o = (!output_enable_n_i && chip_select_n_i != 2'h3) ?
    store[sel] : flip;
  // wait raised at strobe start, held for wait_len_i cycles
  assign ext_wait_in_o = (hold_cnt != 8'h00);
  always @(posedge clk_i) begin
    flip <= ~flip ^ 16'h00a5;
    stb_d <= stb;
    if (!write_enable_n_i && chip_select_n_i != 2'h3) begin
      store[sel] <= bus_i;
    end
    if (hold_cnt != 8'h00) begin
      hold_cnt <= hold_cnt - 8'h01;
    end else if (stb_d && !stb) begin
      hold_cnt <= wait_len_i;
    end
  end
endmodule : amc_mem_model

/* amc_pkg.sv */
package amc_pkg;
  // all counts are stored as the cycle count minus one
  localparam int TA_W = 2;
  localparam int SETUP_W = 4;
  localparam int STROBE_W = 6;
  localparam int HOLD_W = 3;
  localparam int WAIT_W = 8;
  localparam int DATA_W = 16;
  localparam int BANKS = 2;
  localparam int BUF_DEPTH = 2;
  localparam int SYNC_STAGES = 3;
  localparam int CLK_PERIOD_NS = 20;
  localparam logic [3:0] WAIT_CHUNK_LAST = 4'hf;
  localparam logic [5:0] RELEASE_LAST = 6'h3;
  localparam logic [1:0] RST_CS_N = 2'h3;
  localparam logic RST_STROBE_N = 1'h1;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SETUP = 3'h1,
    S_STROBE = 3'h2,
    S_WAIT = 3'h3,
    S_TAIL = 3'h4,
    S_HOLD = 3'h5,
    S_TURN = 3'h6
  } amc_state_e;

  typedef struct packed {
    logic [TA_W-1:0] ta;
    logic [SETUP_W-1:0] rs;
    logic [STROBE_W-1:0] rst;
    logic [HOLD_W-1:0] rh;
    logic [SETUP_W-1:0] ws;
    logic [STROBE_W-1:0] write_strobe_cycles;
    logic [HOLD_W-1:0] wh;
  } amc_cfg_s;
endpackage : amc_pkg

/* amc_seq.sv */
module amc_seq (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic cfg_load_i,
  input wire logic cfg_bank_i,
  input wire logic [1:0] turnaround_cycles_i,
  input wire logic [3:0] read_setup_cycles_i,
  input wire logic [5:0] read_strobe_cycles_i,
  input wire logic [2:0] read_hold_cycles_i,
  input wire logic [3:0] write_setup_cycles_i,
  input wire logic [5:0] write_strobe_cycles_i,
  input wire logic [2:0] write_hold_cycles_i,
  input wire logic wait_cfg_load_i,
  input wire logic [7:0] max_wait_count_i,
  input wire logic extended_wait_mode_i,
  input wire logic select_strobe_i,
  input wire logic burst_mode_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_bank_i,
  input wire logic [15:0] req_wdata_i,
  output logic req_ready_o,
  input wire logic rd_ready_i,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  input wire logic ext_wait_in_i,
  input wire logic [15:0] memory_data_bus_i,
  output logic [15:0] memory_data_bus_o,
  output logic memory_data_bus_oe_n_o,
  output logic [1:0] chip_select_n_o,
  output logic output_enable_n_o,
  output logic write_enable_n_o,
  output logic burst_clock_o,
  output logic [7:0] inserted_wait_count_o,
  output logic timeout_o,
  output logic capture_o
);
  typedef struct packed {
    amc_pkg::amc_state_e state;
    logic [5:0] cnt;
    logic [3:0] sub;
    logic [7:0] wcnt;
    logic [7:0] max_wait_count;
    amc_pkg::amc_cfg_s [1:0] cfg;
    logic wr;
    logic bank;
    logic bm;
    logic ss;
    logic ew;
    logic [1:0] cs_n;
    logic oe_n;
    logic we_n;
    logic doe_n;
    logic [15:0] dout;
    logic bclk;
    logic rdy;
    logic cap;
    logic to;
    logic [2:0] w;
    logic wv;
    logic [15:0] d0;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [1:0][15:0] bufd;
    logic [1:0] bcnt;
    logic rv;
  } amc_st_s;

  amc_st_s st;
  amc_st_s next_st;
  amc_pkg::amc_cfg_s c;
  logic pop;
  logic push;
  logic fin;
  logic [1:0] cnt_b;

  always_comb begin
    next_st = st;
    c = st.cfg[st.bank];
    next_st.cap = 1'h0;
    next_st.to = 1'h0;
    next_st.w = {st.w[1:0], ext_wait_in_i};
    // a wait level counts once the last two stages agree
    if (st.w[1] == st.w[2]) begin
      next_st.wv = st.w[2];
    end
    next_st.d0 = memory_data_bus_i;
    next_st.d1 = st.d0;
    next_st.d2 = st.d1;
    if (cfg_load_i) begin
      next_st.cfg[cfg_bank_i] = {turnaround_cycles_i, read_setup_cycles_i,
        read_strobe_cycles_i, read_hold_cycles_i, write_setup_cycles_i,
        write_strobe_cycles_i, write_hold_cycles_i};
    end
    if (wait_cfg_load_i) begin
      next_st.max_wait_count = max_wait_count_i;
    end
    pop = st.rv && rd_ready_i;
    cnt_b = pop ? st.bcnt - 2'h1 : st.bcnt;
    if (pop) begin
      next_st.bufd[0] = st.bufd[1];
    end
    push = 1'h0;
    fin = 1'h0;
    case (st.state)
      amc_pkg::S_IDLE: begin
        if (req_valid_i && st.rdy) begin
          next_st.bank = req_bank_i;
          next_st.wr = req_write_i;
          next_st.bm = burst_mode_i && !req_write_i;
          next_st.ss = select_strobe_i;
          next_st.ew = extended_wait_mode_i;
          next_st.dout = req_wdata_i;
          next_st.doe_n = !req_write_i;
          next_st.state = amc_pkg::S_SETUP;
          next_st.cnt = req_write_i ? {2'h0, st.cfg[req_bank_i].ws}
            : {2'h0, st.cfg[req_bank_i].rs};
          if (!select_strobe_i) begin
            next_st.cs_n[req_bank_i] = 1'h0;
          end
        end
      end
      amc_pkg::S_SETUP: begin
        if (st.cnt == 6'h0) begin
          next_st.state = amc_pkg::S_STROBE;
          next_st.cnt = st.wr ? c.write_strobe_cycles : c.rst;
          next_st.oe_n = st.wr;
          next_st.we_n = !st.wr;
          next_st.cs_n[st.bank] = 1'h0;
        end else begin
          next_st.cnt = st.cnt - 6'h1;
        end
      end
      amc_pkg::S_STROBE: begin
        // a full buffer holds the burst clock low instead of losing data
        if (!(st.bm && !st.bclk && cnt_b == 2'h2)) begin
          next_st.bclk = st.bm && !st.bclk;
          push = st.bm && !st.bclk;
          if (st.cnt != 6'h0) begin
            next_st.cnt = st.cnt - 6'h1;
          end else if (st.ew && st.wv && !st.bm) begin
            next_st.state = amc_pkg::S_WAIT;
            next_st.sub = amc_pkg::WAIT_CHUNK_LAST;
            next_st.wcnt = 8'h0;
          end else begin
            fin = 1'h1;
          end
        end
      end
      amc_pkg::S_WAIT: begin
        if (!st.wv) begin
          next_st.state = amc_pkg::S_TAIL;
          next_st.cnt = amc_pkg::RELEASE_LAST;
        end else if (st.sub != 4'h0) begin
          next_st.sub = st.sub - 4'h1;
        end else if (st.wcnt == st.max_wait_count) begin
          next_st.to = 1'h1;
          fin = 1'h1;
        end else begin
          next_st.wcnt = st.wcnt + 8'h1;
          next_st.sub = amc_pkg::WAIT_CHUNK_LAST;
        end
      end
      amc_pkg::S_TAIL: begin
        if (st.cnt == 6'h0) begin
          fin = 1'h1;
        end else begin
          next_st.cnt = st.cnt - 6'h1;
        end
      end
      amc_pkg::S_HOLD: begin
        if (st.cnt == 6'h0) begin
          next_st.state = amc_pkg::S_TURN;
          next_st.cnt = {4'h0, c.ta};
          next_st.cs_n = amc_pkg::RST_CS_N;
          next_st.doe_n = 1'h1;
        end else begin
          next_st.cnt = st.cnt - 6'h1;
        end
      end
      amc_pkg::S_TURN: begin
        if (st.cnt == 6'h0) begin
          next_st.state = amc_pkg::S_IDLE;
        end else begin
          next_st.cnt = st.cnt - 6'h1;
        end
      end
      default: begin
        next_st.state = amc_pkg::S_IDLE;
      end
    endcase
    if (fin) begin
      next_st.state = amc_pkg::S_HOLD;
      next_st.cnt = st.wr ? {3'h0, c.wh} : {3'h0, c.rh};
      next_st.oe_n = 1'h1;
      next_st.we_n = 1'h1;
      next_st.bclk = 1'h0;
      push = !st.wr && !st.bm;
      if (st.ss) begin
        next_st.cs_n = amc_pkg::RST_CS_N;
      end
    end
    if (push) begin
      next_st.bufd[cnt_b[0]] = st.d2;
      cnt_b = cnt_b + 2'h1;
    end
    next_st.cap = push;
    next_st.bcnt = cnt_b;
    next_st.rv = cnt_b != 2'h0;
    next_st.rdy = next_st.state == amc_pkg::S_IDLE && cnt_b == 2'h0;
  end

  // all phase counts advance on the peripheral clock only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.cs_n <= amc_pkg::RST_CS_N;
      st.oe_n <= amc_pkg::RST_STROBE_N;
      st.we_n <= amc_pkg::RST_STROBE_N;
      st.doe_n <= 1'h1;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign req_ready_o = st.rdy;
  assign rd_valid_o = st.rv;
  assign rd_data_o = st.bufd[0];
  assign memory_data_bus_o = st.dout;
  assign memory_data_bus_oe_n_o = st.doe_n;
  assign chip_select_n_o = st.cs_n;
  assign output_enable_n_o = st.oe_n;
  assign write_enable_n_o = st.we_n;
  assign burst_clock_o = st.bclk;
  assign inserted_wait_count_o = st.wcnt;
  assign timeout_o = st.to;
  assign capture_o = st.cap;

  property p_strobe_only;
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (!st.oe_n || !st.we_n) |-> (st.state == amc_pkg::S_STROBE
      || st.state == amc_pkg::S_WAIT || st.state == amc_pkg::S_TAIL);
  endproperty
  a_strobe_only: assert property (p_strobe_only)
    else $error("strobe active outside strobe phase");

  property p_setup_cs;
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (st.state == amc_pkg::S_SETUP && !st.ss) |->
      (st.cs_n != 2'h3 && st.oe_n && st.we_n);
  endproperty
  a_setup_cs: assert property (p_setup_cs)
    else $error("chip select missing in setup");

  property p_ss_align;
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    st.ss && st.state != amc_pkg::S_IDLE |->
      ((st.cs_n != 2'h3) == (!st.oe_n || !st.we_n));
  endproperty
  a_ss_align: assert property (p_ss_align)
    else $error("select strobe misaligned");

  property p_hold_cs;
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (st.state == amc_pkg::S_HOLD && !st.ss) |->
      (st.cs_n != 2'h3 && st.oe_n);
  endproperty
  a_hold_cs: assert property (p_hold_cs)
    else $error("chip select dropped in hold");

  property p_hold_turn;
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (st.state == amc_pkg::S_HOLD && st.cnt == 6'h0) ##1 ce_i |->
      st.state == amc_pkg::S_TURN && st.cnt == {4'h0, c.ta};
  endproperty
  a_hold_turn: assert property (p_hold_turn)
    else $error("turnaround not entered after hold");

  property p_wait_limit;
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    st.state == amc_pkg::S_WAIT |-> st.wcnt <= st.max_wait_count;
  endproperty
  a_wait_limit: assert property (p_wait_limit)
    else $error("wait count passed its maximum");

  property p_oe_capture;
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    $rose(st.oe_n) && !st.bm |-> st.cap && st.rv;
  endproperty
  a_oe_capture: assert property (p_oe_capture)
    else $error("read data not captured at strobe end");

  property p_release;
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (st.state == amc_pkg::S_WAIT && !st.wv) ##1 ce_i [*4] |=>
      st.state == amc_pkg::S_HOLD && st.oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("strobe not ended four cycles after wait");

  property p_burst_half;
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    $rose(st.bclk) |-> st.cap ##1 (!st.bclk || !ce_i);
  endproperty
  a_burst_half: assert property (p_burst_half)
    else $error("burst clock high longer than one cycle");
endmodule : amc_seq

/* async_memory_cycle_timing_tb.sv */
module async_memory_cycle_timing_tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
  logic clk = 0, rst_n = 0, cfg_load = 0, cfg_bank = 0, wcfg_load = 0;
  logic [1:0] ta = 0;
  logic [3:0] rs = 0, ws = 0;
  logic [5:0] rst = 0, write_strobe_cycles = 0;
  logic [2:0] rh = 0, wh = 0;
  logic [7:0] max_wait = 0, wait_len = 0;
  logic ew = 0, ss = 0, req_valid = 0, req_write = 0, req_bank = 0;
  logic rd_ready = 0, req_ready, rd_valid, bus_oe_n, oe_n, we_n, to_p, ext_w;
  logic [15:0] req_wdata = 0, bus_out, model_data, rd_data;
  logic [1:0] cs_n;
  logic [15:0] shadow [2];
  logic [15:0] exp_q [$];
  logic [31:0] seed = 32'h0000b0b3;
  int err_total = 0, n_checks = 0, n_to = 0, cs_w, st_w, gap;
  int n_cap = 0, n_bclk = 0;
  logic cap, bclk;
  logic [7:0] wcnt;
  logic [15:0] exp_w;
  amc_seq uut (.clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
    .cfg_load_i(cfg_load), .cfg_bank_i(cfg_bank),
    .turnaround_cycles_i(ta), .read_setup_cycles_i(rs),
    .read_strobe_cycles_i(rst), .read_hold_cycles_i(rh),
    .write_setup_cycles_i(ws), .write_strobe_cycles_i(write_strobe_cycles),
    .write_hold_cycles_i(wh), .wait_cfg_load_i(wcfg_load),
    .max_wait_count_i(max_wait), .extended_wait_mode_i(ew),
    .select_strobe_i(ss), .burst_mode_i(1'b0), .req_valid_i(req_valid),
    .req_write_i(req_write), .req_bank_i(req_bank),
    .req_wdata_i(req_wdata), .req_ready_o(req_ready),
    .rd_ready_i(rd_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .ext_wait_in_i(ext_w),
    .memory_data_bus_i(bus_oe_n ? model_data : bus_out),
    .memory_data_bus_o(bus_out), .memory_data_bus_oe_n_o(bus_oe_n),
    .chip_select_n_o(cs_n), .output_enable_n_o(oe_n),
    .write_enable_n_o(we_n), .burst_clock_o(bclk),
    .inserted_wait_count_o(wcnt), .timeout_o(to_p), .capture_o(cap));
  amc_mem_model mem (.clk_i(clk), .chip_select_n_i(cs_n),
    .output_enable_n_i(oe_n), .write_enable_n_i(we_n), .bus_i(bus_out),
    .wait_len_i(wait_len), .data_o(model_data), .ext_wait_in_o(ext_w));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  initial forever #10 clk = ~clk;
  // consumer stalls at random; each word popped is matched to its note
  always @(posedge clk) begin
    rd_ready <= ^rnd();
    if (to_p === 1'b1) n_to++;
    if (cap === 1'b1) n_cap++;
    if (bclk !== 1'b0) n_bclk++;
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      `CHK(exp_q.size() != 0, 1'b1)
      if (exp_q.size() != 0) begin
        exp_w = exp_q.pop_front();
        `CHK(rd_data, exp_w)
      end
    end
  end
  task automatic cfg(input logic b, input logic [1:0] t,
      input logic [3:0] s, input logic [5:0] st, input logic [2:0] h,
      input logic m_ss, input logic m_ew, input logic [7:0] mw);
    @(posedge clk);
    {ta, rs, ws, rst, write_strobe_cycles, rh, wh} <= {t, s, s, st, st, h, h};
    {ss, ew, max_wait, cfg_bank} <= {m_ss, m_ew, mw, b};
    {cfg_load, wcfg_load} <= 2'h3;
    @(posedge clk);
    {cfg_load, wcfg_load} <= 2'h0;
  endtask : cfg
  task automatic access(input logic w, input logic b, input logic [15:0] d);
    int i;
    i = 0;
    @(posedge clk);
    {req_valid, req_write, req_bank, req_wdata} <= {1'b1, w, b, d};
    do begin
      @(posedge clk);
      i++;
    end while (req_ready !== 1'b1 && i < 400);
    req_valid <= 1'b0;
    if (!w) exp_q.push_back(shadow[b]);
    cs_w = 0;
    st_w = 0;
    do begin
      @(posedge clk);
      i++;
      if (cs_n[b] === 1'b0) cs_w++;
      if ((oe_n & we_n) === 1'b0) st_w++;
    end while (!(cs_w > 0 && cs_n[b] === 1'b1) && i < 800);
    gap = 0;
    do begin
      @(posedge clk);
      gap++;
    end while (req_ready !== 1'b1 && gap < 300);
  endtask : access
  initial begin
    logic [31:0] r;
    logic [15:0] d;
    logic [5:0] st;
    logic b;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 12; k++) begin
      r = (k == 0) ? 32'hffffffff : (k == 1) ? 32'h00000000 : rnd();
      // strobe of four cycles at least lets read data pass the synchroniser
      st = (k == 0) ? 6'h3f : r[21:16] | 6'h03;
      b = r[31];
      d = rnd();
      cfg(b, r[1:0], r[5:2], st, r[8:6], r[9], 1'b0, 8'h00);
      access(1'b1, b, d);
      shadow[b] = d;
      `CHK(cs_w, r[9] ? st + 1 : r[5:2] + st + r[8:6] + 3)
      `CHK(st_w, st + 1)
      if (!r[9]) `CHK(gap, r[1:0] + 1)
      access(1'b0, b, 16'h0000);
      `CHK(cs_w, r[9] ? st + 1 : r[5:2] + st + r[8:6] + 3)
      `CHK(st_w, st + 1)
    end
    @(posedge clk);
    wait_len <= 8'h28;
    cfg(1'b0, 2'h0, 4'h1, 6'h09, 3'h1, 1'b0, 1'b1, 8'h07);
    access(1'b1, 1'b0, 16'h5a3c);
    shadow[0] = 16'h5a3c;
    `CHK(st_w > 30 && st_w < 60, 1'b1)
    `CHK(n_to, 0)
    wait_len <= 8'hfa;
    cfg(1'b0, 2'h0, 4'h1, 6'h09, 3'h1, 1'b0, 1'b1, 8'h00);
    access(1'b0, 1'b0, 16'h0000);
    `CHK(st_w > 20 && st_w < 40, 1'b1)
    `CHK(n_to, 1)
    `CHK(wcnt, 8'h00)
    for (int n = 0; n < 200 && exp_q.size() != 0; n++) @(posedge clk);
    `CHK(exp_q.size(), 0)
    `CHK(n_cap, 13)
    `CHK(n_bclk, 0)
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
endmodule : async_memory_cycle_timing_tb
